// file: dv/bus_ctl.sv
// Two-wire bus controller model: clock and open-drain data.
// Assumes clk is the bench clock; sda_drv low pulls data low.
`timescale 1ns/100ps
`default_nettype none
module bus_ctl
(
	input  wire logic clk,
	input  wire logic sda_in,
	output var  logic scl = 1'b1,
	output var  logic sda_drv = 1'b1
);
	// When set, each bit's high clock phase gets a 30 ns low nick (not start or stop)
	logic nick = 1'b0;
	// One line changes per step, then a 120 ns wait
	task automatic set(input logic c, input logic d);
		scl = c;
		sda_drv = d;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic put_bit(input logic b, output logic d);
		set(1'b0, b);
		set(1'b1, b);
		if (nick)
		begin
			scl = 1'b0;
			#30;
			scl = 1'b1;
			#1;
		end
		d = sda_in;
		set(1'b1, b);
		set(1'b0, b);
	endtask
	// Also a repeated start
	task automatic start();
		set(scl, 1'b1);
		set(1'b1, 1'b1);
		set(1'b1, 1'b0);
		set(1'b0, 1'b0);
	endtask
	task automatic stop();
		set(1'b0, 1'b0);
		set(1'b1, 1'b0);
		set(1'b1, 1'b1);
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic d;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i], d);
		put_bit(1'b1, ack);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] v);
		logic d;
		for (int i = 7; i >= 0; i--)
			put_bit(1'b1, v[i]);
		put_bit(last, d);
	endtask
endmodule // bus_ctl
`default_nettype wire

// file: dv/eeprom_two_wire_sva.sv
// Port checker for the two-wire EEPROM target.
// Assumes sda_i is the settled wire level and a short write timer.
`timescale 1ns/100ps
`default_nettype none
module eeprom_two_wire_sva
	import eeprom_pkg::*;
#(
	parameter int WRITE_CYCLE_COUNT = WRITE_CYCLE_CYCLES
)
(
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       samp_clk,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic [2:0] chip_select_pins,
	input wire logic       write_protect,
	input wire logic       busy
);
	logic       scl_ff;
	logic       sda_ff;
	logic [3:0] rises_ff;
	logic [7:0] stop_age_ff;
	int         busy_len_ff;

	sequence oe_rise;
		$rose(sda_oe);
	endsequence
	sequence busy_rise;
		$rose(busy);
	endsequence

	// Clock rises since last start, cycles since last stop
	always_ff @(posedge samp_clk or posedge rst)
	begin
		if (rst)
		begin
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			rises_ff <= 4'h0;
			stop_age_ff <= 8'hFF;
		end
		else
		begin
			scl_ff <= scl_i;
			sda_ff <= sda_i;
			if (scl_i && scl_ff && sda_ff && !sda_i)
				rises_ff <= 4'h0;
			else if (scl_i && !scl_ff && rises_ff != 4'hF)
				rises_ff <= rises_ff + 4'h1;
			if (scl_i && scl_ff && !sda_ff && sda_i)
				stop_age_ff <= 8'h00;
			else if (stop_age_ff != 8'hFF)
				stop_age_ff <= stop_age_ff + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			busy_len_ff <= 0;
		else
			busy_len_ff <= busy ? busy_len_ff + 1 : 0;
	end

	chk_drive_low: assert property (@(posedge samp_clk) disable iff (rst)
		sda_oe |-> !sda_o) else $error("data driven high");
	chk_reset_quiet: assert property (@(posedge samp_clk) disable iff (rst)
		$fell(rst) |-> (!busy && !sda_oe)[*2]) else $error("active after reset");
	chk_ack_position: assert property (@(posedge samp_clk) disable iff (rst)
		sda_oe |-> rises_ff >= 4'h8) else $error("drive before word end");
	chk_busy_silent: assert property (@(posedge samp_clk) disable iff (rst)
		busy |-> !sda_oe) else $error("drive while busy");
	chk_oe_scl_low: assert property (@(posedge samp_clk) disable iff (rst)
		$changed(sda_oe) |-> !scl_i) else $error("data change with clock high");
	chk_ack_hold: assert property (@(posedge samp_clk) disable iff (rst)
		oe_rise |-> sda_oe[*8]) else $error("drive too short");
	chk_busy_after_stop: assert property (@(posedge samp_clk) disable iff (rst)
		busy_rise |-> stop_age_ff <= 8'h18) else $error("busy without stop");
	chk_busy_length: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(busy) |-> busy_len_ff >= WRITE_CYCLE_COUNT) else $error("busy too short");
	chk_busy_bound: assert property (@(posedge ref_clk) disable iff (rst)
		busy |-> busy_len_ff <= WRITE_CYCLE_COUNT + 12) else $error("busy too long");
endmodule // eeprom_two_wire_sva

bind eeprom_two_wire eeprom_two_wire_sva #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) sva_inst (
	.ref_clk(ref_clk), .rst(rst), .samp_clk(samp_clk), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .chip_select_pins(chip_select_pins),
	.write_protect(write_protect), .busy(busy)
);
`default_nettype wire

// file: dv/eeprom_two_wire_tb.sv
// Self-checking bench for the two-wire EEPROM target.
// Assumes the bus controller model and port checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module eeprom_two_wire_tb
	import eeprom_pkg::*;
;
	localparam int         WC = 300;
	localparam logic [2:0] CS = 3'h5;
	localparam logic [7:0] DEV_W = {DEV_TYPE_CODE, CS, 1'b0};
	localparam logic [7:0] DEV_R = {DEV_TYPE_CODE, CS, 1'b1};
	logic        ref_clk;
	logic        samp_clk;
	logic        rst;
	logic        write_protect;
	logic        scl;
	logic        sda_drv;
	logic        sda_oe;
	logic        busy;
	logic [7:0]  exp_mem [256];
	int          num_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	// Address beside the byte that reads back
	logic [15:0] rows [4] = '{16'h0096, 16'hFE3C, 16'hFFC3, 16'h405A};
	wire logic   sda_w = sda_drv & ~sda_oe;

	eeprom_two_wire #(.WRITE_CYCLE_COUNT(WC)) eeprom_two_wire_inst (
		.ref_clk(ref_clk), .rst(rst), .samp_clk(samp_clk), .scl_i(scl), .sda_i(sda_w),
		.sda_o(), .sda_oe(sda_oe), .chip_select_pins(CS), .write_protect(write_protect),
		.busy(busy)
	);
	bus_ctl bus_ctl_inst (.clk(ref_clk), .sda_in(sda_w), .scl(scl), .sda_drv(sda_drv));

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial
	begin
		samp_clk = 1'b0;
		#1.3;
		forever #3 samp_clk = ~samp_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			$display("unexpected at %0t: timeout", $time);
			close_out();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] b, input logic want);
		logic a;
		bus_ctl_inst.wbyte(b, a);
		chk({7'h00, a}, {7'h00, want}, "ack");
	endtask
	task automatic page_wr(input logic [7:0] a, input int n, input logic [7:0] seed);
		logic [7:0] d;
		bus_ctl_inst.start();
		send(DEV_W, 1'b0);
		send(a, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			d = seed + 8'(i);
			send(d, write_protect);
			if (write_protect)
				break;
			exp_mem[{a[7:4], a[3:0] + 4'(i)}] = d;
		end
		bus_ctl_inst.stop();
		repeat (3) @(posedge ref_clk);
		chk({7'h00, busy}, {7'h00, !write_protect}, "busy");
	endtask
	task automatic poll(input logic early);
		logic a;
		int k;
		k = 0;
		do
		begin
			bus_ctl_inst.start();
			bus_ctl_inst.wbyte(DEV_W, a);
			bus_ctl_inst.stop();
			if (k == 0 && early)
				chk({7'h00, a}, 8'h01, "busy ack");
			k++;
		end
		while (a !== 1'b0 && k < 20);
		chk({7'h00, a}, 8'h00, "poll");
	endtask
	task automatic rd(input logic [7:0] a, input int n, input logic rnd);
		logic [7:0] v;
		if (rnd)
		begin
			bus_ctl_inst.start();
			send(DEV_W, 1'b0);
			send(a, 1'b0);
		end
		bus_ctl_inst.start();
		send(DEV_R, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			bus_ctl_inst.rbyte(i == n - 1, v);
			chk(v, exp_mem[a + 8'(i)], "read");
		end
		bus_ctl_inst.stop();
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		rst = 1'b1;
		write_protect = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge ref_clk);
		chk({6'h00, busy, sda_oe}, 8'h00, "reset");
		$display("test reset done");
		foreach (rows[i])
		begin
			page_wr(rows[i][15:8], 1, rows[i][7:0]);
			poll(1'b0);
			rd(rows[i][15:8], 1, 1'b1);
		end
		$display("test rows done");
		page_wr(8'h2E, 18, 8'h10);
		poll(1'b1);
		rd(8'h20, 16, 1'b0);
		$display("test page done");
		write_protect = 1'b1;
		page_wr(8'h40, 2, 8'h77);
		rd(8'h40, 1, 1'b1);
		write_protect = 1'b0;
		$display("test protect done");
		rd(8'hFE, 3, 1'b1);
		$display("test wrap done");
		bus_ctl_inst.nick = 1'b1;
		rd(8'hFF, 2, 1'b1);
		bus_ctl_inst.nick = 1'b0;
		$display("test glitch done");
		for (int i = 0; i < 2; i++)
		begin
			bus_ctl_inst.start();
			send(i ? {DEV_TYPE_CODE ^ 4'h3, CS, 1'b0} : {DEV_TYPE_CODE, CS ^ 3'h1, 1'b0}, 1'b1);
			bus_ctl_inst.stop();
		end
		$display("test mismatch done");
		close_out();
	end
endmodule // eeprom_two_wire_tb
`default_nettype wire

// file: rtl/eeprom_pkg.sv
// Constants and types shared by the two-wire serial EEPROM target.
// Assumes a 25 MHz reference clock and a free-running sampling clock.
package eeprom_pkg;

	localparam int ADDR_W     = 8;
	localparam int OFFSET_W   = 4;
	localparam int PAGE_BYTES = 16;
	localparam int MEM_BYTES  = 256;

	// Device-type code: arbitrary neutral value
	localparam logic [3:0] DEV_TYPE_CODE = 4'h5;

	localparam logic [3:0] BIT_LAST  = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;

	localparam int REF_CLK_HZ         = 25_000_000;
	localparam int WRITE_CYCLE_MS     = 5;
	localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * (REF_CLK_HZ / 1000);

	localparam int LINK_CLK_PERIOD_NS = 6;
	localparam int GLITCH_NS          = 50;
	localparam int GLITCH_CYCLES      =
		(GLITCH_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;

	localparam logic SCL_RESET = 1'b1;
	localparam logic SDA_RESET = 1'b1;

	typedef enum logic [8:0] {
		ST_IDLE    = 9'b000000001,
		ST_DEVADDR = 9'b000000010,
		ST_DEVACK  = 9'b000000100,
		ST_MEMADDR = 9'b000001000,
		ST_MEMACK  = 9'b000010000,
		ST_WDATA   = 9'b000100000,
		ST_WACK    = 9'b001000000,
		ST_RDATA   = 9'b010000000,
		ST_RACK    = 9'b100000000
	} proto_state_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} bus_evt_t;

	typedef struct packed {
		logic [3:0] type_code;
		logic [2:0] chip_sel;
		logic       rd;
	} dev_word_t;

endpackage

// file: rtl/eeprom_two_wire.sv
// Two-wire serial EEPROM target: protocol engine, page buffer, array, write timer.
// Assumes samp_clk runs free and fast; bus master drives scl; sda is open drain.
//
// Behaviour
// [R1] Accept 1..16 bytes, commit together once
// [R2] Extra data byte increments in-page offset only
// [R3] Offset wraps in page; later bytes overwrite
// [R4] Stop ends write, starts timed programming
// [R5] Protected: ack addresses, nack data, no change
// [R6] Protected page write: nack first byte
// [R7] Busy: nack write address; ack once done
// [R8] Master polls with write-direction address word
// [R9] Read opens like write, direction bit one
// [R10] Counter holds last address plus one
// [R11] Read: ack, then byte MSB first
// [R12] Master nack then stop ends read
// [R13] Read of last address wraps counter zero
// [R14] Write at page end wraps within page
// [R15] Counter undefined until random read sets it
// [R16] Random read: dummy write, restart, read
// [R17] Dummy write acks address, loads counter only
// [R18] Master ack: increment, send next byte
// [R19] Sequential read wraps to zero, continues
// [R20] Ignore scl and sda pulses under 50 ns
// [R21] Power-on reset holds protocol logic idle
// [R22] Address word: type, chip select, direction
// [R23] Mismatched address word: nack, standby
// [R24] Unprotected writes allowed; reads always served (code nacks reads too while busy_ff is set)
// [R25] During programming ignore bus, nack addresses
// [R26] Programming time is parameterised counter
// [R27] Sample inputs, detect start/stop, drive low only
`timescale 1ns/100ps
`default_nettype none
module eeprom_two_wire
	import eeprom_pkg::*;
#(
	parameter int WRITE_CYCLE_COUNT = WRITE_CYCLE_CYCLES,
	parameter int FILTER_CYCLES     = GLITCH_CYCLES
)
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       samp_clk,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output var  logic       sda_o,
	output var  logic       sda_oe,
	input  wire logic [2:0] chip_select_pins,
	input  wire logic       write_protect,
	output var  logic       busy
);

	localparam int CNT_W = $clog2(WRITE_CYCLE_COUNT + 1);

	// Link-domain reset: asserted at once, released on samp_clk
	logic lrst_s1_ff;
	logic lrst_ff;

	always_ff @(posedge samp_clk or posedge rst)
	begin
		if (rst)
		begin
			lrst_s1_ff <= 1'b1;
			lrst_ff    <= 1'b1;
		end
		else
		begin
			lrst_s1_ff <= 1'b0;
			lrst_ff    <= lrst_s1_ff; // R21
		end
	end

	logic scl_f;
	logic sda_f;

	noise_filter #(
		.STABLE_CYCLES (FILTER_CYCLES),
		.RESET_VAL     (SCL_RESET)
	) u_scl_filter (
		.clk  (samp_clk),
		.rst  (lrst_ff),
		.din  (scl_i),
		.dout (scl_f)
	); // R20

	noise_filter #(
		.STABLE_CYCLES (FILTER_CYCLES),
		.RESET_VAL     (SDA_RESET)
	) u_sda_filter (
		.clk  (samp_clk),
		.rst  (lrst_ff),
		.din  (sda_i),
		.dout (sda_f)
	); // R20

	// Static pins through two flops
	logic [3:0] pin_s1_ff;
	logic [3:0] pin_s2_ff;
	logic [2:0] cs_sync;
	logic       wp_sync;

	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
		begin
			pin_s1_ff <= 4'h0;
			pin_s2_ff <= 4'h0;
		end
		else
		begin
			pin_s1_ff <= {write_protect, chip_select_pins};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign cs_sync = pin_s2_ff[2:0];
	assign wp_sync = pin_s2_ff[3];

	// Bus event detection
	logic     scl_q_ff;
	logic     sda_q_ff;
	bus_evt_t evt;

	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
		begin
			scl_q_ff <= SCL_RESET;
			sda_q_ff <= SDA_RESET;
		end
		else
		begin
			scl_q_ff <= scl_f;
			sda_q_ff <= sda_f;
		end
	end

	always_comb
	begin
		evt.start = scl_f & scl_q_ff & sda_q_ff & ~sda_f; // R27
		evt.stop  = scl_f & scl_q_ff & ~sda_q_ff & sda_f; // R27
		evt.rise  = scl_f & ~scl_q_ff;
		evt.fall  = ~scl_f & scl_q_ff;
	end

	proto_state_t               state_ff;
	logic [3:0]                 bit_cnt_ff;
	logic [7:0]                 shift_ff;
	logic [7:0]                 rd_shift_ff;
	logic                       rw_ff;
	logic                       mst_ack_ff;
	logic [ADDR_W-1:0]          addr_cnt_ff;
	logic [ADDR_W-OFFSET_W-1:0] page_ff;
	logic [PAGE_BYTES-1:0]      mask_ff;
	logic [7:0]                 page_buf [PAGE_BYTES];
	logic [7:0]                 mem [MEM_BYTES];
	logic                       busy_ff;
	logic                       req_tgl_ff;
	logic                       done_s1_ff;
	logic                       done_s2_ff;
	logic                       done_s3_ff;
	logic                       done_evt;

	dev_word_t  dev;
	logic       byte_done;
	logic       dev_match;
	logic       data_take;
	logic       rd_load;
	logic [7:0] rd_byte;

	always_comb
	begin
		dev       = dev_word_t'(shift_ff);
		byte_done = evt.fall && (bit_cnt_ff == BIT_LAST);
		dev_match = (dev.type_code == DEV_TYPE_CODE)
			&& (dev.chip_sel == cs_sync) && !busy_ff; // R22 R23 R7 R25
		data_take = (state_ff == ST_WDATA) && byte_done && !wp_sync; // R24
		rd_load   = evt.fall && (((state_ff == ST_DEVACK) && rw_ff)
			|| ((state_ff == ST_RACK) && mst_ack_ff));
		rd_byte   = mem[addr_cnt_ff];
	end

	// Protocol sequencing
	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
		begin
			state_ff   <= ST_IDLE;
			bit_cnt_ff <= BIT_FIRST;
			rw_ff      <= 1'b0;
		end
		else if (evt.stop)
		begin
			state_ff   <= ST_IDLE; // R12
			bit_cnt_ff <= BIT_FIRST;
		end
		else if (evt.start)
		begin
			state_ff   <= ST_DEVADDR; // R9 R16
			bit_cnt_ff <= BIT_FIRST;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
					bit_cnt_ff <= BIT_FIRST;
				ST_DEVADDR, ST_MEMADDR, ST_WDATA, ST_RDATA:
				begin
					if (evt.rise)
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					if (byte_done)
					begin
						bit_cnt_ff <= BIT_FIRST;
						case (state_ff)
							ST_DEVADDR:
							begin
								rw_ff    <= dev.rd; // R9
								state_ff <= dev_match ? ST_DEVACK : ST_IDLE; // R23
							end
							ST_MEMADDR:
								state_ff <= ST_MEMACK;
							ST_WDATA:
								state_ff <= wp_sync ? ST_IDLE : ST_WACK; // R5 R6
							ST_RDATA:
								state_ff <= ST_RACK;
							default:
								state_ff <= ST_IDLE;
						endcase
					end
				end
				ST_DEVACK:
					if (evt.fall)
						state_ff <= rw_ff ? ST_RDATA : ST_MEMADDR; // R11
				ST_MEMACK, ST_WACK:
					if (evt.fall)
						state_ff <= ST_WDATA; // R2
				ST_RACK:
					if (evt.fall)
						state_ff <= mst_ack_ff ? ST_RDATA : ST_IDLE; // R18 R12
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// Receive shifter and master acknowledge
	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
		begin
			shift_ff   <= 8'h00;
			mst_ack_ff <= 1'b0;
		end
		else if (evt.rise)
		begin
			if ((state_ff == ST_DEVADDR) || (state_ff == ST_MEMADDR)
				|| (state_ff == ST_WDATA))
				shift_ff <= {shift_ff[6:0], sda_f};
			if (state_ff == ST_RACK)
				mst_ack_ff <= ~sda_f;
		end
	end

	// Transmit shifter and open-drain drive
	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
		begin
			rd_shift_ff <= 8'h00;
			sda_oe      <= 1'b0;
		end
		else if (evt.start || evt.stop)
			sda_oe <= 1'b0;
		else if (rd_load)
		begin
			rd_shift_ff <= rd_byte; // R17 R18
			sda_oe      <= ~rd_byte[7]; // R11
		end
		else if (evt.fall)
		begin
			case (state_ff)
				ST_DEVADDR:
					if (byte_done)
						sda_oe <= dev_match; // R7 R23
				ST_MEMADDR:
					if (byte_done)
						sda_oe <= 1'b1; // R5 R17
				ST_WDATA:
					if (byte_done)
						sda_oe <= !wp_sync; // R5 R6
				ST_RDATA:
					if (byte_done)
						sda_oe <= 1'b0;
					else
					begin
						rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
						sda_oe      <= ~rd_shift_ff[6]; // R11
					end
				default:
					sda_oe <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0; // R27
	end

	// Address counter; no reset value is promised to users
	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
		begin
			addr_cnt_ff <= 8'h00; // R15
			page_ff     <= 4'h0;
		end
		else if ((state_ff == ST_MEMADDR) && byte_done)
		begin
			addr_cnt_ff <= shift_ff; // R17
			page_ff     <= shift_ff[7:4];
		end
		else if (data_take)
			addr_cnt_ff <= {addr_cnt_ff[7:4], addr_cnt_ff[3:0] + 4'h1}; // R2 R3 R14 R10
		else if ((state_ff == ST_RDATA) && byte_done)
			addr_cnt_ff <= addr_cnt_ff + 8'h01; // R10 R13 R19
	end

	// Page buffer and valid mask
	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
			mask_ff <= '0;
		else if (done_evt)
			mask_ff <= '0;
		else if (evt.start && !busy_ff)
			mask_ff <= '0;
		else if ((state_ff == ST_WDATA) && byte_done && wp_sync)
			mask_ff <= '0; // R5 R6
		else if (data_take)
			mask_ff[addr_cnt_ff[3:0]] <= 1'b1; // R1 R3
	end

	always_ff @(posedge samp_clk)
	begin
		if (data_take)
			page_buf[addr_cnt_ff[3:0]] <= shift_ff; // R3
	end

	// Array committed once, when the timed cycle ends
	always_ff @(posedge samp_clk)
	begin
		if (done_evt)
		begin
			for (int i = 0; i < PAGE_BYTES; i++)
			begin
				if (mask_ff[i])
					mem[{page_ff, OFFSET_W'(i)}] <= page_buf[i]; // R1
			end
		end
	end

	// Busy flag and request toggle toward the timer
	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
		begin
			busy_ff    <= 1'b0;
			req_tgl_ff <= 1'b0;
		end
		else if (done_evt)
			busy_ff <= 1'b0; // R7
		else if (evt.stop && (|mask_ff) && !busy_ff)
		begin
			busy_ff    <= 1'b1; // R4 R26
			req_tgl_ff <= ~req_tgl_ff;
		end
	end

	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
			busy <= 1'b0;
		else
			busy <= busy_ff;
	end

	// Write-cycle timer in the reference domain
	logic             req_s1_ff;
	logic             req_s2_ff;
	logic             req_s3_ff;
	logic             run_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic             done_tgl_ff;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_s3_ff <= 1'b0;
		end
		else
		begin
			req_s1_ff <= req_tgl_ff;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			run_ff      <= 1'b0;
			cnt_ff      <= '0;
			done_tgl_ff <= 1'b0;
		end
		else if (req_s2_ff ^ req_s3_ff)
		begin
			run_ff <= 1'b1; // R26
			cnt_ff <= '0;
		end
		else if (run_ff)
		begin
			if (cnt_ff == CNT_W'(WRITE_CYCLE_COUNT - 1))
			begin
				run_ff      <= 1'b0; // R26
				done_tgl_ff <= ~done_tgl_ff;
			end
			else
				cnt_ff <= cnt_ff + CNT_W'(1);
		end
	end

	always_ff @(posedge samp_clk or posedge lrst_ff)
	begin
		if (lrst_ff)
		begin
			done_s1_ff <= 1'b0;
			done_s2_ff <= 1'b0;
			done_s3_ff <= 1'b0;
		end
		else
		begin
			done_s1_ff <= done_tgl_ff;
			done_s2_ff <= done_s1_ff;
			done_s3_ff <= done_s2_ff;
		end
	end

	assign done_evt = done_s2_ff ^ done_s3_ff;

endmodule // eeprom_two_wire
`default_nettype wire

// file: rtl/noise_filter.sv
// Synchroniser and pulse-width filter for one bus input.
// Assumes clk is the free-running sampling clock of the link.
`timescale 1ns/100ps
`default_nettype none
module noise_filter
	import eeprom_pkg::*;
#(
	parameter int   STABLE_CYCLES = GLITCH_CYCLES,
	parameter logic RESET_VAL     = 1'b1
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output var  logic dout
);

	localparam int CW = $clog2(STABLE_CYCLES + 1);

	logic          sync1_ff;
	logic          sync2_ff;
	logic [CW-1:0] cnt_ff;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_ff <= RESET_VAL;
			sync2_ff <= RESET_VAL;
		end
		else
		begin
			sync1_ff <= din;
			sync2_ff <= sync1_ff;
		end
	end

	// Output follows only after the level held for the full window
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_ff <= '0;
			dout   <= RESET_VAL;
		end
		else if (sync2_ff == dout)
			cnt_ff <= '0;
		else if (cnt_ff == CW'(STABLE_CYCLES - 1))
		begin
			cnt_ff <= '0;
			dout   <= sync2_ff;
		end
		else
			cnt_ff <= cnt_ff + CW'(1);
	end

endmodule // noise_filter
`default_nettype wire
